/* File: rtl/dacc_datapath.sv */
// dual 40-bit accumulator datapath
`timescale 1ns/10ps
module dacc_datapath (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic [15:0] CORE_CTRL_I,
  input wire logic SAT_ENABLE_I,
  input wire dacc_pkg::dacc_op_t OP_I,
  input wire logic LOAD_I,
  input wire logic LOAD_SEL_B_I,
  input wire logic [15:0] LOAD_DATA_I,
  input wire logic STORE_SEL_B_I,
  output logic [15:0] STORE_DATA_O,
  input wire dacc_pkg::dacc_bus_t BUS_I,
  output logic [15:0] BUS_RDATA_O,
  output logic [39:0] ACC_A_O,
  output logic [39:0] ACC_B_O,
  output logic OVF_A_O,
  output logic OVF_B_O,
  output logic SAT_A_O,
  output logic SAT_B_O
);
  wire dacc_pkg::dacc_acc_t acc_w [2];
  wire logic [1:0] ovf_w;
  wire logic [1:0] sat_w;
  logic [15:0] rdata_q;
  logic [15:0] store_q;
  // per-accumulator strobes
  wire logic [1:0] hit_bus;
  wire logic [1:0] hit_load;
  wire logic [1:0] hit_op;

  // winning source of an accumulator's next value
  typedef enum logic [3:0] {
    SRC_HOLD = 4'h1,
    SRC_BUS = 4'h2,
    SRC_LOAD = 4'h4,
    SRC_OP = 4'h8
  } dacc_src_t;

  // sign-extend a guard byte to a bus word
  function automatic logic [15:0] ext_upper(input logic [7:0] u);
    ext_upper = {{8{u[7]}}, u};
  endfunction

  // sign-extend a 32-bit result over the guard byte
  function automatic logic [39:0] fill_upper(input logic [31:0] v);
    fill_upper = {{8{v[31]}}, v};
  endfunction

  // true when a 40-bit value leaves the signed 32-bit range
  function automatic logic beyond32(input logic [39:0] v);
    beyond32 = (v[39:31] != {9{v[31]}});
  endfunction

  // saturation mode code: zero is normal 32-bit saturation
  function automatic logic [1:0] sat_mode(input logic sup, input logic en);
    sat_mode = {sup, ~en};
  endfunction

  // merge a bus word into a part, byte writes keep the high byte
  function automatic logic [15:0] merge_word(
    input logic [15:0] old_w,
    input logic [15:0] new_w,
    input logic byte_lo
  );
    merge_word = byte_lo ? {old_w[15:8], new_w[7:0]} : new_w;
  endfunction

  // saturation limit for the mode and the true sign of the sum
  function automatic logic [39:0] sat_limit(
    input logic neg,
    input logic wide
  );
    logic [31:0] lim32;
    lim32 = neg ? {dacc_pkg::INT_MIN, dacc_pkg::LOW_FILL} :
      {dacc_pkg::INT_MAX, ~dacc_pkg::LOW_FILL};
    if (wide) begin
      sat_limit = neg ? dacc_pkg::ACC_MIN : dacc_pkg::ACC_MAX;
    end else begin
      sat_limit = fill_upper(lim32);
    end
  endfunction

  // accumulator owning a window index
  function automatic logic idx_acc(input logic [2:0] idx);
    idx_acc = (idx >= dacc_pkg::IDX_B_LOW);
  endfunction

  // part within its accumulator for a window index
  function automatic logic [2:0] idx_part(input logic [2:0] idx);
    if (idx >= dacc_pkg::IDX_B_LOW) begin
      idx_part = 3'(idx - dacc_pkg::IDX_B_LOW);
    end else begin
      idx_part = idx;
    end
  endfunction

  // word read from one part of an accumulator
  function automatic logic [15:0] read_part(
    input dacc_pkg::dacc_acc_t acc,
    input logic [2:0] part
  );
    read_part = 16'h0000;
    unique case (part)
      dacc_pkg::IDX_A_LOW: begin
        read_part = acc.low;
      end
      dacc_pkg::IDX_A_HIGH: begin
        read_part = acc.high;
      end
      dacc_pkg::IDX_A_GUARD: begin
        read_part = ext_upper(acc.upper);
      end
      default: begin
        read_part = 16'h0000;
      end
    endcase
  endfunction

  // apply a bus write to the addressed part
  function automatic dacc_pkg::dacc_acc_t bus_write(
    input dacc_pkg::dacc_acc_t acc,
    input dacc_pkg::dacc_bus_t bus,
    input logic [2:0] part
  );
    bus_write = acc;
    unique case (part)
      dacc_pkg::IDX_A_LOW: begin
        bus_write.low = merge_word(acc.low, bus.wdata, bus.byte_lo);
      end
      dacc_pkg::IDX_A_HIGH: begin
        bus_write.high = merge_word(acc.high, bus.wdata, bus.byte_lo);
      end
      dacc_pkg::IDX_A_GUARD: begin
        bus_write.upper = bus.wdata[7:0];
      end
      default: begin
        bus_write = acc;
      end
    endcase
  endfunction

  // format and mode selection
  wire logic int_mode = CORE_CTRL_I[dacc_pkg::CTRL_FMT_BIT];
  wire logic super_sat = CORE_CTRL_I[dacc_pkg::CTRL_SUPSAT_BIT];
  wire logic [1:0] mode = sat_mode(super_sat, SAT_ENABLE_I);
  wire logic wide_mode = (mode != dacc_pkg::MODE_NORMAL);

  // signed 16x16 multiply, operands two's complement
  wire logic signed [15:0] mx = OP_I.op_x;
  wire logic signed [15:0] my = OP_I.op_y;
  wire logic signed [31:0] prod_raw = mx * my;
  wire logic [31:0] prod_frac = prod_raw <<< dacc_pkg::FRAC_SHIFT;
  wire logic [31:0] prod_sel = int_mode ? prod_raw : prod_frac;
  wire logic [39:0] prod_ext = {{8{prod_sel[31]}}, prod_sel};

  // plain two's complement add, format-blind
  wire logic sel = OP_I.sel_b;
  wire logic [39:0] acc_cur = acc_w[sel];
  wire logic [39:0] base = OP_I.is_mpy ? OP_I.addend : acc_cur;
  wire logic [39:0] term = OP_I.is_mpy ? prod_ext : OP_I.addend;
  wire logic [39:0] term_n = OP_I.subtract ? (~term) : term;
  wire logic [40:0] sum41 =
    {1'b0, base} + {1'b0, term_n} + {40'h00_0000_0000, OP_I.subtract};
  wire logic [39:0] sum = sum41[39:0];

  // normal mode keeps 32 bits and sign-extends them
  wire logic [39:0] sum_norm = fill_upper(sum[31:0]);
  wire logic [39:0] result = wide_mode ? sum : sum_norm;

  // overflow beyond 32 bits, and beyond 40 bits for wide saturation
  wire logic ovf32 = beyond32(sum);
  wire logic ovf40 = (base[39] == term_n[39]) & (sum[39] != base[39]);
  wire logic true_neg = ovf40 ? base[39] : sum[39];
  wire logic op_ovf = ovf32;
  wire logic op_sat = SAT_ENABLE_I & (wide_mode ? ovf40 : ovf32);
  wire logic [39:0] sat_res = sat_limit(true_neg, wide_mode);
  wire logic [39:0] op_res = op_sat ? sat_res : result;

  // load value: high word, zero low, sign upper
  wire logic [39:0] load_val =
    {{8{LOAD_DATA_I[15]}}, LOAD_DATA_I, dacc_pkg::LOW_FILL};

  // bus decode
  wire logic bus_acc = idx_acc(BUS_I.idx);
  wire logic [2:0] bus_part = idx_part(BUS_I.idx);

  // per-accumulator write, load and operation strobes
  for (genvar g = 0; g < 2; g++) begin : g_hit
    assign hit_bus[g] = BUS_I.wr & (bus_acc == 1'(g));
    assign hit_load[g] = LOAD_I & (LOAD_SEL_B_I == 1'(g));
    assign hit_op[g] = OP_I.valid & (sel == 1'(g));
  end

  // accumulator registers, priority op over load over bus write
  for (genvar g = 0; g < 2; g++) begin : g_acc
    dacc_src_t src;
    dacc_pkg::dacc_acc_t part_q;
    dacc_pkg::dacc_acc_t part_d;
    logic ovf_q;
    logic ovf_d;
    logic sat_q;
    logic sat_d;

    always_comb begin
      if (hit_op[g]) begin
        src = SRC_OP;
      end else if (hit_load[g]) begin
        src = SRC_LOAD;
      end else if (hit_bus[g]) begin
        src = SRC_BUS;
      end else begin
        src = SRC_HOLD;
      end
    end

    always_comb begin
      part_d = part_q;
      ovf_d = ovf_q;
      sat_d = sat_q;
      unique case (src)
        SRC_OP: begin
          part_d = op_res;
          ovf_d = op_ovf;
          sat_d = sat_q | op_sat;
        end
        SRC_LOAD: begin
          part_d = load_val;
        end
        SRC_BUS: begin
          part_d = bus_write(part_q, BUS_I, bus_part);
        end
        SRC_HOLD: begin
          part_d = part_q;
        end
      endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
        part_q <= dacc_pkg::ACC_RESET;
        ovf_q <= 1'b0;
        sat_q <= 1'b0;
      end else begin
        part_q <= part_d;
        ovf_q <= ovf_d;
        sat_q <= sat_d;
      end
    end

    assign acc_w[g] = part_q;
    assign ovf_w[g] = ovf_q;
    assign sat_w[g] = sat_q;
  end

  // read and store words
  wire logic [15:0] rd_word =
    read_part(acc_w[bus_acc], bus_part);
  wire logic [15:0] store_word = acc_w[STORE_SEL_B_I].high;

  // registered read and store data
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= 16'h0000;
      store_q <= 16'h0000;
    end else begin
      rdata_q <= rd_word;
      store_q <= store_word;
    end
  end

  // outputs straight from registers
  assign BUS_RDATA_O = rdata_q;
  assign STORE_DATA_O = store_q;
  assign ACC_A_O = acc_w[0];
  assign ACC_B_O = acc_w[1];
  assign OVF_A_O = ovf_w[0];
  assign OVF_B_O = ovf_w[1];
  assign SAT_A_O = sat_w[0];
  assign SAT_B_O = sat_w[1];
endmodule // dacc_datapath

/* File: rtl/dacc_pkg.sv */
// package for the dual accumulator datapath
package dacc_pkg;
  localparam int WORD_W = 16;
  localparam int UPPER_W = 8;
  localparam int ACC_W = 40;
  localparam int PROD_W = 32;
  localparam int FRAC_SHIFT = 1;
  // core control bit positions
  localparam int CTRL_FMT_BIT = 0;
  localparam int CTRL_SUPSAT_BIT = 4;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  // register indices in the accumulator window
  localparam logic [2:0] IDX_A_LOW = 3'h0;
  localparam logic [2:0] IDX_A_HIGH = 3'h1;
  localparam logic [2:0] IDX_A_GUARD = 3'h2;
  localparam logic [2:0] IDX_B_LOW = 3'h3;
  localparam logic [2:0] IDX_B_HIGH = 3'h4;
  localparam logic [2:0] IDX_B_GUARD = 3'h5;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [15:0] LOW_FILL = 16'h0000;
  localparam logic [15:0] INT_MIN = 16'h8000;
  localparam logic [15:0] INT_MAX = 16'h7FFF;
  localparam logic [39:0] ACC_MIN = 40'h80_0000_0000;
  localparam logic [39:0] ACC_MAX = 40'h7F_FFFF_FFFF;

  // one accumulator split into its three parts
  typedef struct packed {
    logic [7:0] upper;
    logic [15:0] high;
    logic [15:0] low;
  } dacc_acc_t;

  // dsp operation request
  typedef struct packed {
    logic valid;
    logic sel_b;
    logic is_mpy;
    logic subtract;
    logic [15:0] op_x;
    logic [15:0] op_y;
    logic [39:0] addend;
  } dacc_op_t;

  // data-bus register access
  typedef struct packed {
    logic wr;
    logic byte_lo;
    logic [2:0] idx;
    logic [15:0] wdata;
  } dacc_bus_t;
endpackage

/* File: verification/dacc_datapath_tb.sv */
// self-checking bench for the dual accumulator datapath
`timescale 1ns/10ps
module dacc_datapath_tb;
  typedef struct packed {
    logic fmt;
    logic [15:0] x;
    logic [15:0] y;
    logic [39:0] exp;
  } dacc_row_t;
  dacc_row_t rows [4] = '{'{1'b1, 16'h8000, 16'h7FFF, 40'hFF_C000_8000},
    '{1'b0, 16'h4000, 16'h4000, 40'h00_2000_0000},
    '{1'b0, 16'h8000, 16'h7FFF, 40'hFF_8001_0000},
    '{1'b1, 16'hFFFF, 16'hFFFF, 40'h00_0000_0001}};
  logic CLK_SYS_I = 1'b0, NRST_I = 1'b0, SAT_ENABLE_I = 1'b1, LOAD_I = 1'b0;
  logic LOAD_SEL_B_I = 1'b0, STORE_SEL_B_I = 1'b0;
  logic [15:0] CORE_CTRL_I = 16'h0000, LOAD_DATA_I = 16'h0000;
  dacc_pkg::dacc_op_t OP_I = '0;
  dacc_pkg::dacc_bus_t BUS_I = '0;
  wire logic [15:0] STORE_DATA_O, BUS_RDATA_O;
  wire logic [39:0] ACC_A_O, ACC_B_O;
  wire logic OVF_A_O, OVF_B_O, SAT_A_O, SAT_B_O;
  int miscompares = 0, num_checks = 0, cycles = 0;
  dacc_datapath dut (.CLK_SYS_I, .NRST_I, .CORE_CTRL_I, .SAT_ENABLE_I, .OP_I,
    .LOAD_I, .LOAD_SEL_B_I, .LOAD_DATA_I, .STORE_SEL_B_I, .STORE_DATA_O,
    .BUS_I, .BUS_RDATA_O, .ACC_A_O, .ACC_B_O, .OVF_A_O, .OVF_B_O,
    .SAT_A_O, .SAT_B_O);
  always #12.5 CLK_SYS_I = ~CLK_SYS_I;
  always @(posedge CLK_SYS_I) begin
    cycles++;
    if (cycles == 500) begin
      miscompares++;
      stop_test();
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge CLK_SYS_I);
    #1;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc(6);
    chk(ACC_A_O, 40'h00_0000_0000);
    NRST_I = 1'b1;
    foreach (rows[i]) begin
      CORE_CTRL_I = {15'h0000, rows[i].fmt};
      OP_I = '{1'b1, 1'b0, 1'b1, 1'b0, rows[i].x, rows[i].y, 40'h0};
      cyc(1);
      chk(ACC_A_O, rows[i].exp);
    end
    OP_I = '0;
    LOAD_I = 1'b1;
    LOAD_SEL_B_I = 1'b1;
    LOAD_DATA_I = 16'h8001;
    STORE_SEL_B_I = 1'b1;
    cyc(1);
    LOAD_I = 1'b0;
    chk(ACC_B_O, 40'hFF_8001_0000);
    cyc(1);
    chk(STORE_DATA_O, 16'h8001);
    BUS_I = '{1'b1, 1'b0, dacc_pkg::IDX_A_GUARD, 16'h1280};
    cyc(1);
    BUS_I.wr = 1'b0;
    cyc(1);
    chk(BUS_RDATA_O, 16'hFF80);
    CORE_CTRL_I = 16'h0011;
    OP_I = '{1'b1, 1'b1, 1'b1, 1'b0, 16'h0001, 16'h0001, 40'h10_0000_0000};
    cyc(1);
    OP_I = '0;
    chk(ACC_B_O, 40'h10_0000_0001);
    chk({38'h0, OVF_B_O, SAT_B_O}, 40'h2);
    SAT_ENABLE_I = 1'b0;
    CORE_CTRL_I = 16'h0001;
    OP_I = '{1'b1, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0, 40'hFF_FFFF_FFFE};
    cyc(1);
    OP_I = '0;
    chk(ACC_A_O, 40'h7F_FFFF_FFFF);
    SAT_ENABLE_I = 1'b1;
    LOAD_I = 1'b1;
    LOAD_SEL_B_I = 1'b0;
    LOAD_DATA_I = 16'h7FFF;
    cyc(1);
    LOAD_I = 1'b0;
    OP_I = '{1'b1, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0, 40'h00_0001_0000};
    cyc(1);
    OP_I = '0;
    chk(ACC_A_O, 40'h00_7FFF_FFFF);
    chk({38'h0, OVF_A_O, SAT_A_O}, 40'h3);
    BUS_I = '{1'b1, 1'b0, dacc_pkg::IDX_A_LOW, 16'h1234};
    cyc(1);
    BUS_I = '{1'b1, 1'b1, dacc_pkg::IDX_A_HIGH, 16'hAB55};
    cyc(1);
    BUS_I = '{1'b1, 1'b0, 3'h6, 16'hFFFF};
    cyc(1);
    BUS_I = '{1'b0, 1'b0, dacc_pkg::IDX_A_HIGH, 16'h0000};
    cyc(1);
    chk(BUS_RDATA_O, 16'h7F55);
    chk(ACC_A_O, 40'h00_7F55_1234);
    chk(ACC_B_O, 40'h10_0000_0001);
    chk({38'h0, OVF_A_O, SAT_A_O}, 40'h3);
    stop_test();
  end
endmodule // dacc_datapath_tb

/* File: verification/dacc_properties.sv */
// assertions for the dual accumulator datapath
`timescale 1ns/10ps
module dacc_properties (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic [15:0] CORE_CTRL_I,
  input wire logic SAT_ENABLE_I,
  input wire dacc_pkg::dacc_op_t OP_I,
  input wire logic LOAD_I,
  input wire logic LOAD_SEL_B_I,
  input wire logic [15:0] LOAD_DATA_I,
  input wire logic STORE_SEL_B_I,
  input wire logic [15:0] STORE_DATA_O,
  input wire dacc_pkg::dacc_bus_t BUS_I,
  input wire logic [15:0] BUS_RDATA_O,
  input wire logic [39:0] ACC_A_O,
  input wire logic OVF_A_O,
  input wire logic SAT_A_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  wire logic signed [39:0] prod_w = $signed(OP_I.op_x) * $signed(OP_I.op_y);
  wire logic quiet_w = !OP_I.valid && !LOAD_I;
  wire logic mpy_a_w = OP_I.valid && OP_I.is_mpy && !OP_I.subtract
    && !OP_I.sel_b && OP_I.addend == 40'h00_0000_0000;
  wire logic guard_w = BUS_I.idx == dacc_pkg::IDX_A_GUARD;
  AST_LOAD_A: assert property (LOAD_I && !LOAD_SEL_B_I && !OP_I.valid |=>
    ACC_A_O == {{8{$past(LOAD_DATA_I[15])}}, $past(LOAD_DATA_I), 16'h0000})
    else $error("load alignment wrong");
  AST_STORE_HIGH: assert property (!STORE_SEL_B_I |=>
    STORE_DATA_O == $past(ACC_A_O[31:16])) else $error("store word wrong");
  AST_GUARD_READ: assert property (!BUS_I.wr && guard_w |=>
    BUS_RDATA_O == {{8{$past(ACC_A_O[39])}}, $past(ACC_A_O[39:32])})
    else $error("guard read not sign extended");
  AST_GUARD_WRITE: assert property (BUS_I.wr && guard_w && quiet_w |=>
    ACC_A_O[39:32] == $past(BUS_I.wdata[7:0])) else $error("guard write wrong");
  AST_FLAGS_BUS: assert property (BUS_I.wr && quiet_w |=>
    $stable(OVF_A_O) && $stable(SAT_A_O)) else $error("bus write moved flags");
  AST_INT_MPY: assert property (mpy_a_w && CORE_CTRL_I[0] |=>
    ACC_A_O == $past(prod_w)) else $error("integer product wrong");
  AST_FRAC_MPY: assert property (mpy_a_w && !CORE_CTRL_I[0]
    && OP_I.op_x != 16'h8000 |=> ACC_A_O == ($past(prod_w) <<< 1))
    else $error("fractional product wrong");
  AST_NORMAL_SIGN: assert property (OP_I.valid && !OP_I.sel_b
    && SAT_ENABLE_I && !CORE_CTRL_I[4] |=> ACC_A_O[39:32] == {8{ACC_A_O[31]}})
    else $error("upper part not sign of 32-bit result");
  cover property (LOAD_I);
  cover property (mpy_a_w);
  cover property (BUS_I.wr && guard_w);
endmodule // dacc_properties
bind dacc_datapath dacc_properties u_props (.CLK_SYS_I, .NRST_I,
  .CORE_CTRL_I, .SAT_ENABLE_I, .OP_I, .LOAD_I, .LOAD_SEL_B_I, .LOAD_DATA_I,
  .STORE_SEL_B_I, .STORE_DATA_O, .BUS_I, .BUS_RDATA_O, .ACC_A_O, .OVF_A_O,
  .SAT_A_O);
